/* src/pgm_page_map.sv */
/*
 * Program page selection, data-space map, return stack and readout
 * protection. Assumes the core issues one data access per cycle on
 * the data port and one fetch address per cycle on the fetch port;
 * the program and eeprom arrays themselves sit outside.
 */
`timescale 1ns/1ps
module pgm_page_map
  import pgm_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // core data port
  input  wire logic        data_wr,
  input  wire logic        data_rd,
  input  wire logic [7:0]  data_addr,
  input  wire logic [7:0]  data_wdata,
  output logic      [7:0]  data_rdata,
  output logic             data_hit,
  // core fetch port
  input  wire logic [11:0] fetch_pc,
  output logic      [12:0] prog_addr,
  // rom window to program memory
  output logic      [12:0] win_prog_addr,
  input  wire logic [7:0]  win_prog_data,
  // bank memory side
  output logic             bank_sel_ee,
  output logic             bank_num,
  output logic      [5:0]  bank_offset,
  input  wire logic [7:0]  bank_rdata,
  // return stack
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire logic [11:0] stack_wdata,
  output logic      [11:0] stack_top,
  output logic             stack_full,
  output logic             stack_empty,
  // readout protection
  input  wire logic        opt_readout_protect,
  input  wire logic        erase_done,
  input  wire logic        ext_read_req,
  input  wire logic [12:0] ext_read_addr,
  output logic      [12:0] ext_prog_addr,
  output logic             ext_read_grant,
  output logic             protect_active
);
  import pgm_pkg::*;

  logic [1:0]  page_code_r;
  logic [7:0]  rom_window_pointer_r;
  logic [7:0]  bank_sel_r;
  logic [7:0]  ram_mem [0:DIRECT_RAM_BYTES-1];
  logic [11:0] stack_mem [0:STACK_DEPTH-1];
  logic [2:0]  stack_ptr_r;
  logic [2:0]  stack_ptr_nxt;
  logic        protect_r;
  logic        page_wr;
  logic        page_written_r;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [1:0] map_page(input logic [1:0] code, input logic pc11);
    if (pc11) begin
      map_page = STATIC_PAGE;
    end else begin
      map_page = code;
    end
  endfunction

  assign page_wr = data_wr && (data_addr == ADDR_PAGE_SEL);

  // page code: no reset, only explicit writes
  always_ff @(posedge sys_clk) begin
    if (page_wr) begin
      page_code_r <= data_wdata[PAGE_CODE_HIGH:PAGE_CODE_LOW];
    end
  end

  // first page write seen; the page map, page hold and write-after checks wait for it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      page_written_r <= 1'b0;
    end else if (page_wr) begin
      page_written_r <= 1'b1;
    end
  end

  // registered so the write lands after the current fetch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_addr <= 13'h0000;
    end else begin
      prog_addr <= {map_page(page_code_r, fetch_pc[PC_STATIC_BIT]), fetch_pc[10:0]};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rom_window_pointer_r <= WIN_PTR_RESET;
      bank_sel_r           <= BANK_SEL_RESET;
    end else if (data_wr && data_addr == ADDR_ROM_WIN_PTR) begin
      rom_window_pointer_r <= data_wdata;
    end else if (data_wr && data_addr == ADDR_BANK_SEL) begin
      bank_sel_r <= data_wdata;
    end
  end

  // direct ram, 60 bytes
  always_ff @(posedge sys_clk) begin
    if (data_wr && in_range(data_addr, ADDR_RAM_LO, ADDR_RAM_HI)) begin
      ram_mem[6'(data_addr - ADDR_RAM_LO)] <= data_wdata;
    end
  end

  assign win_prog_addr = {rom_window_pointer_r[6:0], data_addr[5:0]};
  assign bank_sel_ee   = bank_sel_r[BANK_EE_BIT];
  assign bank_num      = bank_sel_r[BANK_NUM_BIT];
  assign bank_offset   = data_addr[5:0];

  // read mux; page select and unmapped addresses read zero with no hit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_rdata <= 8'h00;
      data_hit   <= 1'b0;
    end else if (data_rd) begin
      data_hit <= 1'b1;
      if (in_range(data_addr, ADDR_BANK_LO, ADDR_BANK_HI)) begin
        data_rdata <= bank_rdata;
      end else if (in_range(data_addr, ADDR_WIN_LO, ADDR_WIN_HI)) begin
        data_rdata <= win_prog_data;
      end else if (in_range(data_addr, ADDR_RAM_LO, ADDR_RAM_HI)) begin
        data_rdata <= ram_mem[6'(data_addr - ADDR_RAM_LO)];
      end else if (data_addr == ADDR_ROM_WIN_PTR) begin
        data_rdata <= rom_window_pointer_r;
      end else if (data_addr == ADDR_BANK_SEL) begin
        data_rdata <= bank_sel_r;
      end else begin
        data_rdata <= 8'h00;
        data_hit   <= 1'b0;
      end
    end else begin
      data_hit <= 1'b0;
    end
  end

  // return stack
  always_comb begin
    stack_ptr_nxt = stack_ptr_r;
    if (stack_push && !stack_full) begin
      stack_ptr_nxt = 3'(stack_ptr_r + 3'h1);
    end else if (stack_pop && !stack_empty) begin
      stack_ptr_nxt = 3'(stack_ptr_r - 3'h1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stack_ptr_r <= STACK_PTR_RESET;
    end else begin
      stack_ptr_r <= stack_ptr_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (stack_push && !stack_full) begin
      stack_mem[stack_ptr_r] <= stack_wdata;
    end
  end

  assign stack_full  = (stack_ptr_r == 3'(STACK_DEPTH));
  assign stack_empty = (stack_ptr_r == STACK_PTR_RESET);
  assign stack_top   = stack_empty ? 12'h000 : stack_mem[3'(stack_ptr_r - 3'h1)];

  // protection latch: set by option, cleared only by erasure or reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      protect_r <= 1'b0;
    end else if (opt_readout_protect) begin
      protect_r <= 1'b1;
    end else if (erase_done) begin
      protect_r <= 1'b0;
    end
  end

  assign protect_active = protect_r || opt_readout_protect;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_read_grant <= 1'b0;
      ext_prog_addr  <= 13'h0000;
    end else begin
      ext_read_grant <= ext_read_req && !protect_active;
      ext_prog_addr  <= protect_active ? 13'h0000 : ext_read_addr;
    end
  end

  // assertions: page select and fetch mapping
  static_page_a: assert property (@(posedge sys_clk) disable iff (rst)
    fetch_pc[PC_STATIC_BIT] |=> prog_addr[12:11] == STATIC_PAGE)
    else $error("static page not selected");
  page_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    (page_written_r && !fetch_pc[PC_STATIC_BIT]) |=> prog_addr[12:11] == $past(page_code_r))
    else $error("page code mapped wrongly");
  page_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    page_wr |=> page_code_r == $past(data_wdata[1:0]))
    else $error("page code not stored");
  page_unreadable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (data_rd && data_addr == ADDR_PAGE_SEL) |=> !data_hit)
    else $error("page select answered a read");
  page_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (page_written_r && !page_wr) |=> $stable(page_code_r))
    else $error("page code changed without a write");
  alias_offset_a: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> prog_addr[10:0] == $past(fetch_pc[10:0]))
    else $error("fetch offset lost");
  write_after_a: assert property (@(posedge sys_clk) disable iff (rst)
    (page_written_r && page_wr && !fetch_pc[PC_STATIC_BIT]) |=> prog_addr[12:11] == $past(page_code_r))
    else $error("page write hit current fetch");

  // assertions: data map
  win_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    win_prog_addr[5:0] == data_addr[5:0])
    else $error("window offset wrong");
  win_pointer_a: assert property (@(posedge sys_clk) disable iff (rst)
    (data_wr && data_addr == ADDR_ROM_WIN_PTR) |=> win_prog_addr[12:6] == $past(data_wdata[6:0]))
    else $error("window pointer not stored");
  win_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (data_rd && in_range(data_addr, ADDR_WIN_LO, ADDR_WIN_HI)) |=> data_rdata == $past(win_prog_data))
    else $error("window read data wrong");
  ram_hit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (data_rd && in_range(data_addr, ADDR_RAM_LO, ADDR_RAM_HI)) |=> data_hit)
    else $error("ram read not answered");
  read_hit_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    !data_rd |=> !data_hit)
    else $error("hit without a read");
  rdata_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !data_rd |=> $stable(data_rdata))
    else $error("read data changed without a read");
  bank_select_a: assert property (@(posedge sys_clk) disable iff (rst)
    (data_wr && data_addr == ADDR_BANK_SEL) |=> {bank_sel_ee, bank_num} == $past(data_wdata[1:0]))
    else $error("bank select not stored");
  bank_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (data_rd && in_range(data_addr, ADDR_BANK_LO, ADDR_BANK_HI)) |=> data_rdata == $past(bank_rdata))
    else $error("bank read data wrong");

  // assertions: return stack
  stack_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
    stack_ptr_r <= 3'(STACK_DEPTH))
    else $error("stack pointer out of range");
  stack_push_a: assert property (@(posedge sys_clk) disable iff (rst)
    (stack_push && !stack_full) |=> stack_top == $past(stack_wdata))
    else $error("stack push lost");
  push_pointer_a: assert property (@(posedge sys_clk) disable iff (rst)
    (stack_push && !stack_full) |=> stack_ptr_r == 3'($past(stack_ptr_r) + 3'h1))
    else $error("push did not advance pointer");
  pop_pointer_a: assert property (@(posedge sys_clk) disable iff (rst)
    (stack_pop && !stack_push && !stack_empty) |=> stack_ptr_r == 3'($past(stack_ptr_r) - 3'h1))
    else $error("pop did not retreat pointer");
  full_push_a: assert property (@(posedge sys_clk) disable iff (rst)
    (stack_push && !stack_pop && stack_full) |=> stack_full)
    else $error("push past full changed stack");
  empty_pop_a: assert property (@(posedge sys_clk) disable iff (rst)
    (stack_pop && !stack_push && stack_empty) |=> stack_empty)
    else $error("pop past empty changed stack");
  empty_top_a: assert property (@(posedge sys_clk) disable iff (rst)
    stack_empty |-> stack_top == 12'h000)
    else $error("empty stack shows an entry");

  // assertions: readout protection
  protect_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    protect_active |=> !ext_read_grant)
    else $error("readout granted while protected");
  protect_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    protect_active |=> ext_prog_addr == 13'h0000)
    else $error("address passed while protected");
  protect_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    opt_readout_protect |=> protect_r)
    else $error("protection not latched");
  grant_open_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ext_read_req && !protect_active) |=> ext_read_grant)
    else $error("open readout not granted");
  ext_addr_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
    !protect_active |=> ext_prog_addr == $past(ext_read_addr))
    else $error("open readout address lost");
  protect_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (protect_r && !erase_done) |=> protect_r)
    else $error("protection dropped without erase");
  erase_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    (erase_done && !opt_readout_protect) |=> !protect_r)
    else $error("erase did not clear protection");
endmodule

/* src/pgm_pkg.sv */
/*
 * Package for the program page select and data map block: data-space
 * addresses, field positions, sizes, reset values and bank select bits.
 * Assumes an 8-bit core data bus and a 12-bit program counter.
 */
package pgm_pkg;
  localparam logic [7:0]  ADDR_PAGE_SEL    = 8'hCA;
  localparam logic [7:0]  ADDR_ROM_WIN_PTR = 8'hC9;
  localparam logic [7:0]  ADDR_BANK_SEL    = 8'hCB;
  localparam logic [7:0]  ADDR_BANK_LO     = 8'h00;
  localparam logic [7:0]  ADDR_BANK_HI     = 8'h3F;
  localparam logic [7:0]  ADDR_WIN_LO      = 8'h40;
  localparam logic [7:0]  ADDR_WIN_HI      = 8'h7F;
  localparam logic [7:0]  ADDR_RAM_LO      = 8'h84;
  localparam logic [7:0]  ADDR_RAM_HI      = 8'hBF;
  localparam int          PAGE_CODE_LOW    = 0;
  localparam int          PAGE_CODE_HIGH   = 1;
  localparam int          PC_STATIC_BIT    = 11;
  localparam logic [1:0]  STATIC_PAGE      = 2'h1;
  localparam int          STACK_DEPTH      = 6;
  localparam int          PC_WIDTH         = 12;
  localparam int          WIN_BYTES        = 64;
  localparam int          DIRECT_RAM_BYTES = 60;
  localparam int          BANK_BYTES       = 64;
  localparam logic [7:0]  BANK_SEL_RESET   = 8'h00;
  localparam logic [7:0]  WIN_PTR_RESET    = 8'h00;
  localparam logic [2:0]  STACK_PTR_RESET  = 3'h0;
  // bank select codes: bit 1 chooses eeprom, bit 0 the bank
  localparam int          BANK_EE_BIT      = 1;
  localparam int          BANK_NUM_BIT     = 0;
endpackage

/* verification/test_pgm_page_map.sv */
/*
 * Self-checking bench for pgm_page_map: page select, data map, return stack, readout protection.
 * Assumes the design package and module under src/; every input is driven at the falling clock edge.
 */
`timescale 1ns/1ps
module test_pgm_page_map;
  import pgm_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        data_wr = 1'b0, data_rd = 1'b0;
  logic [7:0]  data_addr = 8'h00, data_wdata = 8'h00, data_rdata;
  logic        data_hit;
  logic [11:0] fetch_pc = 12'h000;
  logic [12:0] prog_addr, win_prog_addr, ext_prog_addr;
  logic [7:0]  win_prog_data = 8'h00, bank_rdata = 8'h00;
  logic        bank_sel_ee, bank_num;
  logic [5:0]  bank_offset;
  logic        stack_push = 1'b0, stack_pop = 1'b0, stack_full, stack_empty;
  logic [11:0] stack_wdata = 12'h000, stack_top;
  logic        opt_readout_protect = 1'b0, erase_done = 1'b0, ext_read_req = 1'b0;
  logic [12:0] ext_read_addr = 13'h0000;
  logic        ext_read_grant, protect_active;
  int          err_count = 0;
  int          checks = 0;

  always #5 sys_clk = ~sys_clk;

  pgm_page_map dut (.sys_clk(sys_clk), .rst(rst), .data_wr(data_wr), .data_rd(data_rd),
    .data_addr(data_addr), .data_wdata(data_wdata), .data_rdata(data_rdata), .data_hit(data_hit),
    .fetch_pc(fetch_pc), .prog_addr(prog_addr), .win_prog_addr(win_prog_addr),
    .win_prog_data(win_prog_data), .bank_sel_ee(bank_sel_ee), .bank_num(bank_num),
    .bank_offset(bank_offset), .bank_rdata(bank_rdata), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_wdata(stack_wdata), .stack_top(stack_top),
    .stack_full(stack_full), .stack_empty(stack_empty), .opt_readout_protect(opt_readout_protect),
    .erase_done(erase_done), .ext_read_req(ext_read_req), .ext_read_addr(ext_read_addr),
    .ext_prog_addr(ext_prog_addr), .ext_read_grant(ext_read_grant), .protect_active(protect_active));

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic step;
    @(negedge sys_clk);
  endtask

  // idle cycle first: a strobe is never dropped and raised in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step;
    data_wr = 1'b1; data_addr = a; data_wdata = d;
    step;
    data_wr = 1'b0;
  endtask

  // read result is settled on return
  task automatic rd(input logic [7:0] a);
    step;
    data_rd = 1'b1; data_addr = a;
    step;
    data_rd = 1'b0;
  endtask

  task automatic fetch(input logic [11:0] pc, input logic [12:0] exp);
    fetch_pc = pc;
    step;
    cmp(prog_addr, exp);
  endtask

  task automatic push(input logic [11:0] v);
    step;
    stack_push = 1'b1; stack_wdata = v;
    step;
    stack_push = 1'b0;
  endtask

  initial begin
    #20000;
    err_count++;
    print_verdict;
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    step;
    cmp(prog_addr, 13'h0000);
    cmp(data_hit, 1'b0);
    cmp(stack_empty, 1'b1);
    cmp(ext_read_grant, 1'b0);
    rst = 1'b0;
    $display("test done: reset");
    // upper six bits set must not matter
    for (int c = 0; c < 4; c++) begin
      wr(8'hCA, 8'hFC | 8'(c));
      fetch(12'h7FF, {c[1:0], 11'h7FF});
      fetch(12'hF5A, 13'h0F5A);
    end
    wr(8'hCA, 8'h00);
    fetch_pc = 12'h123;
    wr(8'hCA, 8'h03);
    cmp(prog_addr, 13'h0123);
    step;
    cmp(prog_addr, 13'h1923);
    $display("test done: page select");
    rd(8'hCA);
    cmp(data_hit, 1'b0);
    cmp(data_rdata, 8'h00);
    wr(8'h84, 8'h5A);
    wr(8'hBF, 8'hC3);
    rd(8'h84);
    cmp(data_hit, 1'b1);
    cmp(data_rdata, 8'h5A);
    rd(8'hBF);
    cmp(data_hit, 1'b1);
    cmp(data_rdata, 8'hC3);
    rd(8'hD0);
    cmp(data_hit, 1'b0);
    wr(8'hC9, 8'h05);
    win_prog_data = 8'hA5;
    rd(8'h47);
    cmp(data_rdata, 8'hA5);
    cmp(data_hit, 1'b1);
    cmp(win_prog_addr, {7'h05, 6'h07});
    wr(8'hCB, 8'h02);
    cmp(bank_sel_ee, 1'b1);
    cmp(bank_num, 1'b0);
    bank_rdata = 8'h3C;
    rd(8'h2A);
    cmp(data_rdata, 8'h3C);
    cmp(bank_offset, 6'h2A);
    wr(8'hCB, 8'h01);
    cmp(bank_sel_ee, 1'b0);
    cmp(bank_num, 1'b1);
    $display("test done: data map");
    for (int i = 0; i < 6; i++)
      push(12'h100 + 12'(i));
    cmp(stack_full, 1'b1);
    push(12'hEEE);
    for (int i = 5; i >= 0; i--) begin
      cmp(stack_top, 12'h100 + 12'(i));
      stack_pop = 1'b1;
      step;
      stack_pop = 1'b0;
      step;
    end
    cmp(stack_empty, 1'b1);
    cmp(stack_top, 12'h000);
    fetch(12'h456, 13'h1C56);
    $display("test done: return stack");
    opt_readout_protect = 1'b1; ext_read_req = 1'b1; ext_read_addr = 13'h1234;
    step;
    cmp(protect_active, 1'b1);
    step;
    cmp(ext_read_grant, 1'b0);
    cmp(ext_prog_addr, 13'h0000);
    erase_done = 1'b1;
    step;
    erase_done = 1'b0;
    opt_readout_protect = 1'b0;
    repeat (2) step;
    cmp(protect_active, 1'b1);
    cmp(ext_read_grant, 1'b0);
    erase_done = 1'b1;
    step;
    erase_done = 1'b0;
    repeat (2) step;
    cmp(protect_active, 1'b0);
    cmp(ext_read_grant, 1'b1);
    cmp(ext_prog_addr, 13'h1234);
    ext_read_req = 1'b0;
    $display("test done: readout protection");
    print_verdict;
  end
endmodule
